/* File: rtl/two_wire_pkg.sv */
// Purpose: Shared constants for the two-wire register slave and its master
// Assumes: Byte-wide registers, seven-bit target address
// Notes: Times are in ns; counts derive from the 10 MHz system clock
package two_wire_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h3f;
  localparam int NUM_REGS = 32;
  localparam int REG_AW = 5;
  localparam logic [4:0] FIRST_RW_REG = 5'h14;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int QUARTER_NS = 1000;
  localparam int QUARTER_CYCLES = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [0:0] DIR_WRITE = 1'b0;
  localparam logic [0:0] DIR_READ = 1'b1;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

/* File: rtl/two_wire_if.sv */
// Purpose: Two-wire bus joining the register slave and the master
// Assumes: Open-drain data line; enables low while a party drives low
// Notes: The wire levels are resolved here: data from both enables, clock from clk_oe_n alone
`timescale 1ns/1ps
interface two_wire_if;
  logic serial_bus_clock_in;
  logic clk_oe_n;
  logic mst_data_oe_n;
  logic slv_data_oe_n;
  logic serial_bus_data_line;
  // Open-drain resolution, pulled high when nobody pulls low
  assign serial_bus_clock_in = clk_oe_n;
  assign serial_bus_data_line = mst_data_oe_n & slv_data_oe_n;
  modport target (input serial_bus_clock_in, input serial_bus_data_line, output slv_data_oe_n);
  modport controller (input serial_bus_clock_in, input serial_bus_data_line, output clk_oe_n,
    output mst_data_oe_n);
endinterface

/* File: rtl/two_wire_register_slave.sv */
// Purpose: Target end of the two-wire bus with a bank of byte registers
// Assumes: Bus clock sampled by clk_sys through three flip-flops
// Notes: One data byte per transaction; no auto increment
// How it works
// - Target only; clock is input, data shared
// - Answers one hardwired seven-bit address only
// - Thirty-two byte registers, each own address
// - Access type fixed at design time
// - Sequencing driven by bus clock edges and start/stop conditions only
// - Exactly one data byte per transaction
// - Keep last register address for short reads
// - Master sets address, repeated start, reads
// - Master separates repeated reads by transaction
// - Data shifted most significant bit first
// - Accept ack or nack after read byte
// - Read sequence with repeated start
// - Write is address, register, data bytes
// - Acknowledge three write bytes, then stop
// - Register address sent as full byte
`timescale 1ns/1ps
module two_wire_register_slave
  import two_wire_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  two_wire_if.target bus,
  input wire logic [7:0] status_in [two_wire_pkg::NUM_REGS],
  output logic [7:0] control_out [two_wire_pkg::NUM_REGS],
  output logic write_strobe
);
  import two_wire_pkg::*;

  typedef enum logic [2:0] {IDLE, ADDR, REGA, DATA_W, DATA_R, MASTER_ACK, IGNORE} phase_e;

  phase_e phase;
  logic scl_now;
  logic sda_now;
  logic scl_q;
  logic sda_q;
  logic [2:0] bit_cnt;
  logic [7:0] shifter;
  logic [REG_AW-1:0] reg_addr;
  logic ack_phase;
  logic sda_drive_low;
  logic [7:0] regs [NUM_REGS];

  // Both bus lines come from outside clk_sys and are filtered alike
  pin_filter #(.IDLE_LEVEL(1'b1)) i_scl_filter
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(bus.serial_bus_clock_in),
    .level(scl_now)
  );
  pin_filter #(.IDLE_LEVEL(1'b1)) i_sda_filter
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(bus.serial_bus_data_line),
    .level(sda_now)
  );

  // Edge detection from the bus clock; start and stop from both filtered bus lines
  wire scl_rise = scl_now & ~scl_q;
  wire scl_fall = ~scl_now & scl_q;
  wire start_seen = scl_now & scl_q & sda_q & ~sda_now;
  wire stop_seen = scl_now & scl_q & ~sda_q & sda_now;
  wire [7:0] rx_byte = {shifter[6:0], sda_now};
  wire addr_match = (rx_byte[7:1] == TARGET_ADDR);
  wire reg_writable = (reg_addr >= FIRST_RW_REG);
  wire [7:0] read_byte = reg_writable ? regs[reg_addr] : status_in[reg_addr];

  // Previous filtered levels; idle high so reset gives no false edge
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_now;
      sda_q <= sda_now;
    end
  end

  // Bit sequencer: sample on rising, change drive on falling
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      phase <= IDLE;
      bit_cnt <= 3'h0;
      shifter <= 8'h00;
      reg_addr <= '0;
      ack_phase <= 1'b0;
      sda_drive_low <= 1'b0;
      write_strobe <= 1'b0;
    end
    else
    begin
      write_strobe <= 1'b0;
      if (start_seen)
      begin
        phase <= ADDR; // Repeated start handled here too
        bit_cnt <= 3'h0;
        ack_phase <= 1'b0;
        sda_drive_low <= 1'b0;
      end
      else if (stop_seen)
      begin
        phase <= IDLE;
        ack_phase <= 1'b0;
        sda_drive_low <= 1'b0;
      end
      else if (scl_rise && !ack_phase)
      begin
        shifter <= rx_byte;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == LAST_BIT)
        begin
          case (phase)
            ADDR: phase <= addr_match ? (rx_byte[0] == DIR_READ ? DATA_R : REGA) : IGNORE;
            REGA:
            begin
              reg_addr <= rx_byte[REG_AW-1:0];
              phase <= DATA_W;
            end
            DATA_W:
            begin
              write_strobe <= 1'b1;
              phase <= IGNORE;
            end
            DATA_R: phase <= MASTER_ACK;
            MASTER_ACK: phase <= IGNORE;
            IGNORE: phase <= IGNORE;
            default: phase <= IDLE;
          endcase
          ack_phase <= (phase == ADDR) ? addr_match : (phase == REGA || phase == DATA_W);
        end
      end
      else if (scl_fall)
      begin
        if (ack_phase)
        begin
          // Hold ack through the ninth bit, then release, or in DATA_R drive the first read bit
          if (sda_drive_low)
          begin
            sda_drive_low <= (phase == DATA_R) ? ~read_byte[7] : 1'b0;
            shifter <= read_byte;
            ack_phase <= 1'b0;
          end
          else
            sda_drive_low <= 1'b1;
        end
        else if (phase == DATA_R)
        begin
          // Own level shifts back in, so the next bit sits on top
          sda_drive_low <= ~shifter[LAST_BIT];
          if (bit_cnt == 3'h0)
            phase <= MASTER_ACK;
        end
        else
          sda_drive_low <= 1'b0;
      end
    end
  end

  // Register bank; read-only ones never take a write
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      regs <= '{default: RESET_VALUE};
    else if (write_strobe && reg_writable)
      regs[reg_addr] <= shifter;
  end

  // Control outputs show the bank; read-only slots keep the reset value
  assign control_out = regs;
  assign bus.slv_data_oe_n = ~sda_drive_low;
endmodule

// Three-stage sampler for a line from outside the clk_sys domain
module pin_filter
#(
  parameter logic IDLE_LEVEL = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin,
  output logic level
);
  logic [2:0] stage;

  // A change counts once stages two and three agree
  wire agree = (stage[1] == stage[2]);

  // Only stage two reads stage one, so a metastable first flop never fans out
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      stage <= {3{IDLE_LEVEL}};
      level <= IDLE_LEVEL;
    end
    else
    begin
      stage <= {stage[1:0], pin};
      if (agree)
        level <= stage[2];
    end
  end
endmodule

/* File: rtl/two_wire_master.sv */
// Purpose: Controller end that writes or reads one register per request
// Assumes: Bus clock made by dividing clk_sys
// Notes: Idles between transactions, which keeps reads separated
`timescale 1ns/1ps
module two_wire_master
  import two_wire_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  two_wire_if.controller bus,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [7:0] req_reg,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  output logic rsp_nack
);
  import two_wire_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_START, M_BITS, M_RESTART, M_STOP} mstate_e;

  mstate_e state;
  logic [4:0] tick;
  logic [1:0] quarter;
  logic [3:0] bit_idx;
  logic [1:0] byte_idx;
  logic [7:0] tx;
  logic [7:0] rx;
  logic is_read;
  logic [7:0] reg_q;
  logic [7:0] data_q;
  logic clk_hi;
  logic sda_lo;
  logic nack_seen;
  logic sda_in;

  // Data line comes back from the far end, so it is filtered like a pin
  pin_filter #(.IDLE_LEVEL(1'b1)) i_pin_filter
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(bus.serial_bus_data_line),
    .level(sda_in)
  );

  // Bytes: 0 address, 1 register, then data (write) or address again and data (read)
  wire q_end = (tick == 5'(QUARTER_CYCLES - 1));
  wire restart_due = is_read && (byte_idx == 2'h1);
  wire last_byte = is_read ? (byte_idx == 2'h3) : (byte_idx == 2'h2);
  wire in_data_read = is_read && (byte_idx == 2'h3);

  // Quarter-period timer and four-phase bit engine
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= M_IDLE;
      tick <= 5'h0;
      quarter <= 2'h0;
      bit_idx <= 4'h0;
      byte_idx <= 2'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      is_read <= 1'b0;
      reg_q <= 8'h00;
      data_q <= 8'h00;
      clk_hi <= 1'b1;
      sda_lo <= 1'b0;
      nack_seen <= 1'b0;
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      tick <= q_end ? 5'h0 : tick + 5'h1;
      if (state == M_IDLE)
      begin
        tick <= 5'h0;
        quarter <= 2'h0;
        if (req_valid)
        begin
          state <= M_START;
          is_read <= req_read;
          reg_q <= req_reg;
          data_q <= req_data;
          nack_seen <= 1'b0;
          byte_idx <= 2'h0;
        end
      end
      else if (q_end)
      begin
        quarter <= quarter + 2'h1;
        case (state)
          M_START, M_RESTART:
          begin
            // Data falls while clock high, then clock falls
            if (quarter == 2'h0) clk_hi <= 1'b1;
            if (quarter == 2'h0) sda_lo <= 1'b0;
            if (quarter == 2'h1) sda_lo <= 1'b1;
            if (quarter == 2'h3)
            begin
              clk_hi <= 1'b0;
              state <= M_BITS;
              bit_idx <= 4'h0;
              tx <= {TARGET_ADDR, (state == M_RESTART) ? DIR_READ : DIR_WRITE};
            end
          end
          M_BITS:
          begin
            if (quarter == 2'h0)
              sda_lo <= (bit_idx < 4'h8) ? (in_data_read ? 1'b0 : ~tx[7]) : 1'b0;
            if (quarter == 2'h0 && bit_idx == 4'h8 && in_data_read)
              sda_lo <= 1'b1; // Ack the single data byte
            if (quarter == 2'h1) clk_hi <= 1'b1;
            if (quarter == 2'h2)
            begin
              if (bit_idx < 4'h8) rx <= {rx[6:0], sda_in};
              else if (!in_data_read && sda_in) nack_seen <= 1'b1;
            end
            if (quarter == 2'h3)
            begin
              clk_hi <= 1'b0;
              tx <= {tx[6:0], 1'b0};
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx == 4'h8)
              begin
                byte_idx <= byte_idx + 2'h1;
                bit_idx <= 4'h0;
                tx <= (byte_idx == 2'h0) ? reg_q : data_q;
                if (nack_seen || last_byte) state <= M_STOP;
                else if (restart_due) state <= M_RESTART;
              end
            end
          end
          M_STOP:
          begin
            // Data low, clock high, then data rises
            if (quarter == 2'h0) sda_lo <= 1'b1;
            if (quarter == 2'h1) clk_hi <= 1'b1;
            if (quarter == 2'h2) sda_lo <= 1'b0;
            if (quarter == 2'h3)
            begin
              state <= M_IDLE;
              rsp_valid <= 1'b1;
              rsp_nack <= nack_seen;
              rsp_data <= rx;
            end
          end
          default: state <= M_IDLE;
        endcase
      end
    end
  end

  // Ready only when idle; the stop/idle gap separates reads
  assign req_ready = (state == M_IDLE);
  assign bus.clk_oe_n = clk_hi;
  assign bus.mst_data_oe_n = ~sda_lo;
endmodule

/* File: bench/two_wire_chk.sv */
// Purpose: Protocol checker on the two-wire bus between both ends
// Assumes: Lines sampled by clk_sys; bytes tracked from bus clock rises
// Notes: A repeated start restarts the byte index
`timescale 1ns/1ps
module two_wire_chk
  import two_wire_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serial_bus_clock_in,
  input wire logic clk_oe_n,
  input wire logic mst_data_oe_n,
  input wire logic slv_data_oe_n,
  input wire logic serial_bus_data_line
);
  logic scl_q, sda_q, in_frame, rd, match;
  logic [3:0] bits;
  logic [1:0] idx;
  logic [7:0] sh;
  wire rise = serial_bus_clock_in & ~scl_q;
  wire start_c = scl_q & serial_bus_clock_in & sda_q & ~serial_bus_data_line;
  wire stop_c = scl_q & serial_bus_clock_in & ~sda_q & serial_bus_data_line;
  wire ack_bit = rise & (bits == 4'h8);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Frame and byte tracker; reset forces idle lines so no false start
  always_ff @(posedge clk_sys)
  begin
    scl_q <= sys_rst | serial_bus_clock_in;
    sda_q <= sys_rst | serial_bus_data_line;
    if (sys_rst | start_c)
    begin
      in_frame <= ~sys_rst;
      bits <= 4'h0;
      idx <= 2'h0;
    end
    else if (stop_c)
      in_frame <= 1'b0;
    else if (ack_bit)
    begin
      bits <= 4'h0;
      idx <= idx + 2'h1;
    end
    else if (rise)
    begin
      bits <= bits + 4'h1;
      sh <= {sh[6:0], serial_bus_data_line};
    end
  end
  // Address match and direction of the current segment
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      {rd, match} <= 2'b00;
    else if (ack_bit && idx == 2'h0)
      {rd, match} <= {sh[0], sh[7:1] == TARGET_ADDR};
  end
  chk_start_by_master: assert property (start_c |-> !mst_data_oe_n)
    else $error("start not made by the controller");
  chk_slave_low_clock: assert property ($changed(slv_data_oe_n) |-> !serial_bus_clock_in)
    else $error("target moved data while clock high");
  chk_clock_idle_high: assert property (!in_frame |-> clk_oe_n)
    else $error("bus clock not parked high outside a frame");
  chk_slave_idle_quiet: assert property (!in_frame |-> slv_data_oe_n)
    else $error("target drives data outside a frame");
  chk_addr_ack: assert property (ack_bit && idx == 2'h0 |-> slv_data_oe_n == (sh[7:1] != TARGET_ADDR))
    else $error("address acknowledge wrong");
  chk_write_ack: assert property (ack_bit && idx != 2'h0 && match && !rd |-> !slv_data_oe_n)
    else $error("target missed a byte acknowledge");
  chk_read_release: assert property (rise && rd && idx == 2'h1 && bits < 4'h8 |-> mst_data_oe_n)
    else $error("controller drives during read data");
  chk_read_end_ack: assert property (ack_bit && rd && idx == 2'h1 |-> slv_data_oe_n)
    else $error("target holds line at master acknowledge");
  chk_one_byte: assert property (ack_bit |-> idx <= (rd ? 2'h1 : 2'h2))
    else $error("too many bytes in a frame");
  chk_stop_complete: assert property (stop_c |-> idx == (rd ? 2'h2 : 2'h3))
    else $error("stop before the last acknowledge");
  cover property (start_c && in_frame);
  cover property (stop_c && !rd);
  cover property (stop_c && rd);
  cover property (ack_bit && rd && idx == 2'h1);
endmodule

/* File: bench/two_wire_register_slave_tb.sv */
// Purpose: Both bus ends joined; writes and reads checked at ports and wire
// Assumes: Controller is driven through its request port only
// Notes: Bytes are captured on the wire for order checks
`timescale 1ns/1ps
module two_wire_register_slave_tb;
  import two_wire_pkg::*;
  logic clk_sys, sys_rst, req_valid, req_read, req_ready, rsp_valid, rsp_nack, write_strobe;
  logic [7:0] req_reg, req_data, rsp_data, sda_byte, d;
  logic [4:0] a;
  logic [7:0] status [NUM_REGS];
  logic [7:0] ctrl [NUM_REGS];
  logic [7:0] model [NUM_REGS];
  logic [7:0] wire_q [$];
  logic [31:0] seed = 32'h3a32;
  int fail_count, compares, cycles, strobes, wbit, s;
  two_wire_if bus();
  two_wire_register_slave i_two_wire_register_slave (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
    .status_in(status), .control_out(ctrl), .write_strobe(write_strobe));
  two_wire_master i_two_wire_master (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus), .req_valid(req_valid),
    .req_read(req_read), .req_reg(req_reg), .req_data(req_data), .req_ready(req_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_nack(rsp_nack));
  two_wire_chk i_two_wire_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .serial_bus_clock_in(bus.serial_bus_clock_in),
    .clk_oe_n(bus.clk_oe_n), .mst_data_oe_n(bus.mst_data_oe_n), .slv_data_oe_n(bus.slv_data_oe_n),
    .serial_bus_data_line(bus.serial_bus_data_line));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Wire bytes, ack bit skipped; a start restarts the count
  always @(posedge bus.serial_bus_clock_in)
  begin
    if (wbit < 8)
      sda_byte = {sda_byte[6:0], bus.serial_bus_data_line};
    wbit = wbit + 1;
    if (wbit == 8)
      wire_q.push_back(sda_byte);
    if (wbit == 9)
      wbit = 0;
  end
  always @(negedge bus.serial_bus_data_line)
    if (bus.serial_bus_clock_in === 1'b1)
      wbit = 0;
  // Strobe count and hang guard; a hung bus ends in the report
  always @(posedge clk_sys)
  begin
    if (write_strobe === 1'b1)
      strobes++;
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      close_out();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected read value: bank content for writable slots, status input otherwise
  function automatic logic [7:0] exp_read(input logic [4:0] ra);
    return (ra >= FIRST_RW_REG) ? model[ra] : status[ra];
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One request; waits idle first so requests never collide
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [7:0] val);
    int n;
    wire_q.delete();
    n = 0;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    req_valid = 1'b1;
    req_read = rd;
    req_reg = {3'h0, ra};
    req_data = val;
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check("response", {7'h0, rsp_valid}, 8'h1);
    check("nack", {7'h0, rsp_nack}, 8'h0);
    check("byte count", 8'(wire_q.size()), rd ? 8'h4 : 8'h3);
    check("addr byte", wire_q[0], {TARGET_ADDR, DIR_WRITE});
    check("reg byte", wire_q[1], {3'h0, ra});
    if (rd)
    begin
      check("restart byte", wire_q[2], {TARGET_ADDR, DIR_READ});
      check("wire data", wire_q[3], val);
      check("rsp data", rsp_data, val);
    end
    else
      check("write byte", wire_q[2], val);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_reg = 8'h00;
    req_data = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      status[i] = 8'(xs());
      model[i] = RESET_VALUE;
    end
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int r = FIRST_RW_REG; r < NUM_REGS; r++)
      check("reset value", ctrl[r], RESET_VALUE);
    $display("test reset done");
    // Writable slots: both ends of the range, then random
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? FIRST_RW_REG : (i == 1) ? 5'h1f : FIRST_RW_REG + 5'(xs() % 12);
      d = 8'(xs());
      s = strobes;
      xfer(1'b0, a, d);
      model[a] = d;
      check("control", ctrl[a], d);
      check("strobes", 8'(strobes - s), 8'h1);
      xfer(1'b1, a, exp_read(a));
    end
    $display("test rw done");
    // Read-only slots: write acked, content still the status input
    for (int i = 0; i < 4; i++)
    begin
      a = (i == 0) ? 5'h00 : (i == 1) ? 5'h13 : 5'(xs() % 20);
      xfer(1'b0, a, ~status[a]);
      check("ro slot", ctrl[a], RESET_VALUE);
      xfer(1'b1, a, exp_read(a));
    end
    for (int r = FIRST_RW_REG; r < NUM_REGS; r++)
      check("rw kept", ctrl[r], model[r]);
    $display("test ro done");
    close_out();
  end
endmodule
